// file: shared/dsr_pkg.sv
// Purpose: constants and carrier types for the status read-back responder
// Assumes: 8-bit parallel command port, one 100 MHz clock
// Notes: read-back reset values match the power-on state of the settings
package dsr_pkg;

  // clock rate, used for host timing figures
  localparam int CLK_MHZ = 100;

  // status-read command codes
  localparam logic [7:0] CMD_ACCESS = 8'h0B;
  localparam logic [7:0] CMD_PIXEL = 8'h0C;
  localparam logic [7:0] CMD_IMAGE = 8'h0D;
  localparam logic [7:0] CMD_SIGNAL = 8'h0E;

  // read-back reset values
  localparam logic [7:0] ACCESS_RST = 8'h00;
  localparam logic [7:0] PIXEL_RST = 8'h66;
  localparam logic [7:0] IMAGE_VAL = 8'h00;
  localparam logic [7:0] SIGNAL_RST = 8'h3C;

  // byte returned on the dummy read
  localparam logic [7:0] DUMMY_VAL = 8'h00;

  // field positions of the read-back bytes
  localparam int ACC_PAGE_BIT = 7;
  localparam int ACC_COL_BIT = 6;
  localparam int ACC_EXCH_BIT = 5;
  localparam int ACC_LINE_BIT = 4;
  localparam int ACC_RGB_BIT = 3;
  localparam int PIX_RIM_BIT = 7;
  localparam int SIG_TE_BIT = 7;
  localparam int SIG_MODE_BIT = 6;
  localparam int SIG_DE_BIT = 2;

  // the only defined pixel-format codes
  localparam logic [2:0] FMT_16BPP = 3'h5;
  localparam logic [2:0] FMT_18BPP = 3'h6;

  // pin synchroniser width, the pin count
  localparam int SYNC_WIDTH = 12;

  // which read-back a transaction returns
  typedef enum logic [1:0] {
    DSR_SEL_ACCESS = 2'h0,
    DSR_SEL_PIXEL = 2'h1,
    DSR_SEL_IMAGE = 2'h2,
    DSR_SEL_SIGNAL = 2'h3
  } dsr_sel_t;

  // transaction progress
  typedef enum logic [1:0] {
    DSR_IDLE = 2'h0,
    DSR_DUMMY = 2'h1,
    DSR_PARAM = 2'h2
  } dsr_state_t;

  // command port pins, all active low except data/command select and the data byte
  typedef struct packed {
    logic cs_n;
    logic dc;
    logic wr_n;
    logic rd_n;
    logic [7:0] data;
  } dsr_pins_t;

  // current settings reported by the read-backs
  typedef struct packed {
    logic [7:0] access;
    logic rim;
    logic [2:0] dpi;
    logic [2:0] dbi;
    logic tear_line_enable;
    logic tear_mode;
    logic [2:0] rgb_ctrl;
    logic data_enable_sync_select;
  } dsr_settings_t;

endpackage : dsr_pkg

// file: hw/dsr_pin_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk_i
// Notes: output moves only when the second and third stages agree
`timescale 1ns/10ps
module dsr_pin_sync
  import dsr_pkg::*;
#(
  parameter int WIDTH = SYNC_WIDTH,
  parameter logic [WIDTH-1:0] RST_VAL = '1
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // raw pins and filtered result
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] stage1; // metastable stage, read only by stage2
  logic [WIDTH-1:0] stage2; // first settled stage
  logic [WIDTH-1:0] stage3; // comparison stage

  ////////////////////////////////////////////////////////////////////
  // one filter per pin
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge clk_i)
      begin
        if (!reset_n_i)
        begin
          stage1[g] <= RST_VAL[g];
          stage2[g] <= RST_VAL[g];
          stage3[g] <= RST_VAL[g];
          level_o[g] <= RST_VAL[g];
        end
        else
        begin
          stage1[g] <= pin_i[g];
          stage2[g] <= stage1[g];
          stage3[g] <= stage2[g];
          // a glitch seen by only one stage never passes
          if (stage2[g] == stage3[g])
          begin
            level_o[g] <= stage3[g];
          end
        end
      end
    end
  endgenerate

endmodule : dsr_pin_sync

// file: hw/dsr_readback.sv
// Purpose: answers the four status-read commands on the command port
// Assumes: settings come from same-clock logic; pins are asynchronous
// Notes: host holds each strobe level for at least eight clocks
// Notes on behaviour
// - bit 6 mirrors column address order
// - bit 5 mirrors row/column exchange
// - bit 4 mirrors line refresh order
// - bit 3 mirrors colour component order
// - dummy read precedes the one parameter
// - pixel byte is rim, rgb and host formats
// - image-mode byte is always zero
// - signal byte packs tearing, rgb control, de
// - bit 7 set while tearing output on
// - bit 6 is tearing output mode
// - bit 7 mirrors page address order
// - only 16 and 18 bit codes defined
`timescale 1ns/10ps
module dsr_readback
  import dsr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // command port pins
  input wire dsr_pins_t pins_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  // current settings from the write-command logic
  input wire dsr_settings_t settings_i,
  // pixel-format codes both defined
  output logic format_defined_o
);

  ////////////////////////////////////////////////////////////////////
  // declarations
  dsr_pins_t pin_lvl; // filtered pin levels
  dsr_pins_t pin_prev; // previous filtered levels
  dsr_settings_t shadow; // settings as read back
  dsr_state_t state; // transaction progress
  dsr_sel_t sel; // selected read-back
  logic wr_rise; // end of a host write cycle
  logic rd_fall; // start of a host read cycle
  logic rd_rise; // end of a host read cycle
  logic selected; // chip select asserted
  logic [7:0] param_byte; // byte for the current selection

  // true when a command code is one of the four status reads
  function automatic logic is_status_cmd(input logic [7:0] code);
    is_status_cmd = (code >= CMD_ACCESS) && (code <= CMD_SIGNAL);
  endfunction : is_status_cmd

  // pixel-format code has a defined meaning
  function automatic logic fmt_ok(input logic [2:0] code);
    fmt_ok = (code == FMT_16BPP) || (code == FMT_18BPP);
  endfunction : fmt_ok

  ////////////////////////////////////////////////////////////////////
  // pin synchroniser
  dsr_pin_sync #(
    .WIDTH(SYNC_WIDTH),
    .RST_VAL({4'hB, 8'h00}) // idle pins: deselected, command, strobes high
  ) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(pins_i),
    .level_o(pin_lvl)
  );

  // previous levels for edge detection
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      pin_prev <= {4'hB, 8'h00}; // same idle levels, so no false edge after reset
    end
    else
    begin
      pin_prev <= pin_lvl;
    end
  end

  assign selected = !pin_lvl.cs_n;
  assign wr_rise = selected && pin_lvl.wr_n && !pin_prev.wr_n;
  assign rd_fall = selected && !pin_lvl.rd_n && pin_prev.rd_n;
  assign rd_rise = pin_lvl.rd_n && !pin_prev.rd_n;

  ////////////////////////////////////////////////////////////////////
  // shadow of the settings, reset to the power-on values
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      shadow <= {ACCESS_RST, PIXEL_RST[7:4], PIXEL_RST[2:0],
                 SIGNAL_RST[7:2]};
    end
    else
    begin
      shadow <= settings_i;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // parameter byte assembly
  always_comb
  begin
    param_byte = 8'h00;
    case (sel)
      DSR_SEL_ACCESS:
      begin
        // page, column, exchange, line, colour order; rest zero
        param_byte = {shadow.access[7:3], 3'h0};
      end
      DSR_SEL_PIXEL:
      begin
        param_byte = {shadow.rim, shadow.dpi, 1'h0, shadow.dbi};
      end
      DSR_SEL_IMAGE:
      begin
        param_byte = IMAGE_VAL;
      end
      DSR_SEL_SIGNAL:
      begin
        // tearing on, tearing mode, rgb control, de select
        param_byte = {shadow.tear_line_enable, shadow.tear_mode,
                      shadow.rgb_ctrl, shadow.data_enable_sync_select,
                      2'h0};
      end
      default:
      begin
        param_byte = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // transaction sequencer: command, dummy read, parameter read
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state <= DSR_IDLE;
      sel <= DSR_SEL_ACCESS;
    end
    else if (wr_rise)
    begin
      // any write restarts; data writes abandon a pending read
      if (!pin_lvl.dc && is_status_cmd(pin_lvl.data))
      begin
        state <= DSR_DUMMY;
        sel <= dsr_sel_t'(pin_lvl.data[1:0] - 2'h3);
      end
      else
      begin
        state <= DSR_IDLE;
      end
    end
    else if (rd_rise && !pin_prev.cs_n)
    begin
      case (state)
        DSR_DUMMY:
        begin
          state <= DSR_PARAM;
        end
        DSR_PARAM:
        begin
          // one parameter only; further reads get nothing
          state <= DSR_IDLE;
        end
        default:
        begin
          state <= DSR_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // data bus drive, only inside a read cycle of a status read
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      data_o <= 8'h00;
      data_oe_n_o <= 1'h1;
    end
    else if (rd_fall && (state == DSR_DUMMY))
    begin
      data_o <= DUMMY_VAL;
      data_oe_n_o <= 1'h0;
    end
    else if (rd_fall && (state == DSR_PARAM))
    begin
      data_o <= param_byte;
      data_oe_n_o <= 1'h0;
    end
    else if (rd_rise || !selected)
    begin
      // release promptly so the host can turn the bus round
      data_oe_n_o <= 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // format code check, a flag for the surrounding logic
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      format_defined_o <= 1'h1;
    end
    else
    begin
      format_defined_o <= fmt_ok(shadow.dpi) && fmt_ok(shadow.dbi);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  sequence s_param_read;
    (state == DSR_PARAM) && rd_fall;
  endsequence

  sequence s_sel_access;
    s_param_read and (sel == DSR_SEL_ACCESS);
  endsequence

  property p_col_order;
    @(posedge clk_i) disable iff (!reset_n_i)
    s_sel_access |=> data_o[ACC_COL_BIT] == $past(shadow.access[ACC_COL_BIT]);
  endproperty
  a_col_order: assert property (p_col_order) else $error("column order wrong");

  property p_exch;
    @(posedge clk_i) disable iff (!reset_n_i)
    s_sel_access |=> data_o[ACC_EXCH_BIT] == $past(shadow.access[ACC_EXCH_BIT]);
  endproperty
  a_exch: assert property (p_exch) else $error("exchange bit wrong");

  property p_line;
    @(posedge clk_i) disable iff (!reset_n_i)
    s_sel_access |=> data_o[ACC_LINE_BIT] == $past(shadow.access[ACC_LINE_BIT]);
  endproperty
  a_line: assert property (p_line) else $error("line order wrong");

  property p_rgb;
    @(posedge clk_i) disable iff (!reset_n_i)
    s_sel_access |=> data_o[ACC_RGB_BIT] == $past(shadow.access[ACC_RGB_BIT]);
  endproperty
  a_rgb: assert property (p_rgb) else $error("colour order wrong");

  property p_page;
    @(posedge clk_i) disable iff (!reset_n_i)
    s_sel_access |=> data_o[ACC_PAGE_BIT] == $past(shadow.access[ACC_PAGE_BIT])
      && data_o[2:0] == 3'h0;
  endproperty
  a_page: assert property (p_page) else $error("page order wrong");

  property p_dummy;
    @(posedge clk_i) disable iff (!reset_n_i)
    (state == DSR_DUMMY) && rd_fall |=> !data_oe_n_o && data_o == DUMMY_VAL;
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy read wrong");

  property p_pixel;
    @(posedge clk_i) disable iff (!reset_n_i)
    s_param_read and (sel == DSR_SEL_PIXEL) |=>
      data_o == {$past(shadow.rim), $past(shadow.dpi), 1'h0, $past(shadow.dbi)};
  endproperty
  a_pixel: assert property (p_pixel) else $error("pixel byte wrong");

  property p_image;
    @(posedge clk_i) disable iff (!reset_n_i)
    s_param_read and (sel == DSR_SEL_IMAGE) |=> data_o == 8'h00;
  endproperty
  a_image: assert property (p_image) else $error("image byte not zero");

  property p_signal;
    @(posedge clk_i) disable iff (!reset_n_i)
    s_param_read and (sel == DSR_SEL_SIGNAL) |=>
      data_o[SIG_TE_BIT] == $past(shadow.tear_line_enable)
      && data_o[SIG_MODE_BIT] == $past(shadow.tear_mode)
      && data_o[SIG_DE_BIT] == $past(shadow.data_enable_sync_select);
  endproperty
  a_signal: assert property (p_signal) else $error("signal byte wrong");

  property p_fmt;
    @(posedge clk_i) disable iff (!reset_n_i)
    ##1 format_defined_o == (fmt_ok($past(shadow.dpi)) && fmt_ok($past(shadow.dbi)));
  endproperty
  a_fmt: assert property (p_fmt) else $error("format flag wrong");

  property p_release;
    @(posedge clk_i) disable iff (!reset_n_i)
    (state == DSR_IDLE) && !rd_fall && $stable(state) |=> $stable(data_oe_n_o) || data_oe_n_o;
  endproperty
  a_release: assert property (p_release) else $error("bus driven outside read");

endmodule : dsr_readback

// file: testbench/dsr_host_model.sv
// Purpose: host processor model driving the command port of the read-back block
// Assumes: strobe phases of eight clocks, inputs changed 1 ns after the edge
// Notes: released host data lines toggle every clock so a stale byte never matches
`timescale 1ns/10ps
module dsr_host_model
  import dsr_pkg::*;
(
  // clock
  input wire logic clk_i,
  // device answer on the shared data lines
  input wire logic [7:0] data_i,
  input wire logic data_oe_n_i,
  // command port pins as seen by the device
  output dsr_pins_t pins_o
);
  logic cs_n = 1'b1; // chip select, idle high
  logic dc = 1'b0; // 0 command, 1 data
  logic wr_n = 1'b1; // write strobe
  logic rd_n = 1'b1; // read strobe
  logic hdrive = 1'b0; // host owns the data lines
  logic [7:0] hdata = 8'hA5; // host side of the data lines

  ////////////////////////////////////////////////////////////////////////////
  // released lines wander, no pull on this bus
  always @(posedge clk_i)
    if (!hdrive)
      hdata <= ~hdata;

  // wire level: the device wins while it drives
  assign pins_o = {cs_n, dc, wr_n, rd_n, data_oe_n_i ? hdata : data_i};

  ////////////////////////////////////////////////////////////////////////////
  // wait n edges, then step off the edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : hold

  // command write, data held through the high phase so the late sample is safe
  task automatic send_cmd(input logic [7:0] code);
    cs_n = 1'b0;
    dc = 1'b0;
    hdrive = 1'b1;
    hdata = code;
    wr_n = 1'b0;
    hold(8);
    wr_n = 1'b1;
    hold(8);
    hdrive = 1'b0;
  endtask : send_cmd

  // one read: first after a command is the dummy, second the parameter
  task automatic read_byte(output logic [7:0] val, output logic drv);
    // selects the port too, so a read straight after reset is seen
    cs_n = 1'b0;
    dc = 1'b1;
    rd_n = 1'b0;
    repeat (8) @(posedge clk_i);
    val = data_i;
    drv = ~data_oe_n_i;
    #1;
    rd_n = 1'b1;
    hold(8);
  endtask : read_byte

  // end of transaction
  task automatic release_port();
    cs_n = 1'b1;
    hold(8);
  endtask : release_port
endmodule : dsr_host_model

// file: testbench/display_status_readback_test.sv
// Purpose: self-checking bench for the status read-back responder
// Assumes: settings change only while the port is idle
// Notes: expected bytes come from an integer model of the byte layouts
`timescale 1ns/10ps
module display_status_readback_test
  import dsr_pkg::*;
;
  logic clk_i = 1'b0; // 100 MHz
  logic reset_n_i = 1'b0; // synchronous, active low
  dsr_settings_t settings_i; // current settings
  dsr_pins_t pins; // resolved port pins
  logic [7:0] data_o; // device read data
  logic data_oe_n_o; // device drive enable
  logic format_defined_o; // both codes defined
  int err_count = 0;
  int checks = 0;
  logic [31:0] lfsr = 32'hD81B; // random source
  int acc_v, rim_v, dpi_v, dbi_v, te_v, md_v, rgb_v, de_v; // model state

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  dsr_readback u_dsr_readback (.clk_i(clk_i), .reset_n_i(reset_n_i), .pins_i(pins),
    .data_o(data_o), .data_oe_n_o(data_oe_n_o), .settings_i(settings_i),
    .format_defined_o(format_defined_o));

  dsr_host_model u_dsr_host_model (.clk_i(clk_i), .data_i(data_o),
    .data_oe_n_i(data_oe_n_o), .pins_o(pins));

  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  // galois step, taps fixed
  function automatic logic [31:0] step(input logic [31:0] r);
    return {r[30:0], 1'b0} ^ (r[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : step

  // parameter byte per command; -1 where the device must stay silent
  function automatic int model(input int code);
    case (code)
      'h0B: return acc_v & 'hF8;
      'h0C: return rim_v * 128 + dpi_v * 16 + dbi_v;
      'h0D: return 0;
      'h0E: return te_v * 128 + md_v * 64 + rgb_v * 8 + de_v * 4;
      default: return -1;
    endcase
  endfunction : model

  // load settings from the model state
  task automatic apply(input int a, input int r, input int dp, input int db,
    input int t, input int m, input int rc, input int d);
    acc_v = a; rim_v = r; dpi_v = dp; dbi_v = db;
    te_v = t; md_v = m; rgb_v = rc; de_v = d;
    settings_i = {a[7:0], r[0], dp[2:0], db[2:0], t[0], m[0], rc[2:0], d[0]};
  endtask : apply

  // full transaction: command, dummy, parameter, one read too many
  task automatic txn(input int code);
    logic [7:0] val;
    logic drv;
    int exp;
    exp = model(code);
    u_dsr_host_model.send_cmd(code[7:0]);
    u_dsr_host_model.read_byte(val, drv);
    check({7'h0, drv}, {7'h0, exp >= 0});
    if (exp >= 0)
      check(val, DUMMY_VAL);
    u_dsr_host_model.read_byte(val, drv);
    check({7'h0, drv}, {7'h0, exp >= 0});
    if (exp >= 0)
      check(val, exp[7:0]);
    check({7'h0, data_oe_n_o}, 8'h01);
    u_dsr_host_model.read_byte(val, drv);
    check({7'h0, drv}, 8'h00);
    u_dsr_host_model.release_port();
  endtask : txn

  // reset pulse with idle outputs checked inside it
  task automatic do_reset();
    reset_n_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    check({6'h0, data_oe_n_o, format_defined_o}, 8'h03);
    check(data_o, 8'h00);
    reset_n_i = 1'b1;
    @(posedge clk_i);
    #1;
  endtask : do_reset

  // verdict, the only exit
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  // watchdog against a hung sequence
  initial
  begin
    repeat (90000) @(posedge clk_i);
    err_count++;
    end_sim();
  end

  // main sequence
  initial
  begin
    logic [7:0] v;
    logic d;
    apply(0, 0, 6, 6, 0, 0, 7, 1); // power-on settings: 00 66 00 3C
    do_reset();
    for (int c = 'h0B; c <= 'h0E; c++)
      txn(c);
    // random settings, every command each time
    for (int i = 0; i < 12; i++)
    begin
      lfsr = step(step(lfsr));
      apply(lfsr[7:0], lfsr[13], lfsr[8] ? (lfsr[9] ? 5 : 6) : lfsr[12:10],
        lfsr[14] ? (lfsr[15] ? 6 : 5) : lfsr[18:16], lfsr[19], lfsr[20],
        lfsr[23:21], lfsr[24]);
      u_dsr_host_model.hold(8);
      check({7'h0, format_defined_o}, {7'h0, (dpi_v == 5 || dpi_v == 6)
        && (dbi_v == 5 || dbi_v == 6)});
      for (int c = 'h0B; c <= 'h0E; c++)
        txn(c);
    end
    // unknown codes leave the bus alone
    txn('h0F);
    txn('h0A);
    // reset in mid-transaction clears the sequence
    u_dsr_host_model.send_cmd(CMD_PIXEL);
    u_dsr_host_model.read_byte(v, d);
    u_dsr_host_model.release_port();
    do_reset();
    u_dsr_host_model.read_byte(v, d);
    check({7'h0, d}, 8'h00);
    u_dsr_host_model.release_port();
    // a full transaction still works after the mid-run reset
    txn(CMD_SIGNAL);
    end_sim();
  end
endmodule : display_status_readback_test
